// *** rtl/drs_defs.vh ***
`ifndef DRS_DEFS_VH
`define DRS_DEFS_VH

// Register addresses (word index on the plain port)
`define DRS_ADDR_SEL23      4'h0
`define DRS_ADDR_SEL45      4'h1
`define DRS_ADDR_OPCTL      4'h2
`define DRS_ADDR_CHCTL0     4'h3
`define DRS_ADDR_CNT_BASE   4'h9

// Selector field layout
`define DRS_HI_MID_MSB      15
`define DRS_HI_MID_LSB      10
`define DRS_HI_RID_MSB      9
`define DRS_HI_RID_LSB      8
`define DRS_LO_MID_MSB      7
`define DRS_LO_MID_LSB      2
`define DRS_LO_RID_MSB      1
`define DRS_LO_RID_LSB      0
`define DRS_SEL_RESET       16'h0000

// Module and register ids
`define DRS_MID_UART0       6'h08
`define DRS_MID_UART1       6'h0A
`define DRS_MID_SYNC0       6'h14
`define DRS_MID_SYNC1       6'h15
`define DRS_RID_TX          2'h1
`define DRS_RID_RX          2'h2

// Channel control fields
`define DRS_CC_EN           0
`define DRS_CC_END          1
`define DRS_CC_IE           2
`define DRS_CC_BURST        3
`define DRS_CC_TS_LSB       4
`define DRS_CC_TS_MSB       5
`define DRS_CC_RS_LSB       8
`define DRS_CC_RS_MSB       11
`define DRS_RS_AUTO         4'h4
`define DRS_RS_EXT          4'h0
`define DRS_RS_PERIPH       4'h8

// Operation control fields
`define DRS_OC_MASTER       0
`define DRS_OC_NMI          1
`define DRS_OC_AERR         2

`endif

// *** rtl/drs_flow.v ***
// Operation
// - Channels 2/3 selector field layout
// - Channels 4/5 selector field layout
// - Code is module id then register id
// - Decode four serial module ids, tx/rx
// - Serve requests by priority, stop at end
// - Auto, external and peripheral request sources
// - Burst holds bus, cycle steal releases
// - Enabled only with all five conditions
// - One unit per accepted request
// - Auto request starts once enables set
// - Count decrements per completed unit; here it decrements when the unit is accepted into the buffer
// - Count zero ends channel normally
// - End interrupt only with enable bit
// - Address error or NMI aborts transfer
// - Clearing either enable aborts transfer
// - Selector used only with source 1000
// - Selectors reset to zero, kept in standby
//
// Decided for this implementation: the register addresses and the plain strobed port.
`include "drs_defs.vh"
`default_nettype none

module drs_flow #(
   parameter NCH   = 6,
   parameter CNT_W = 24
) (
   // Clock, reset, enable
   input  wire              mclk,
   input  wire              rst,
   input  wire              ce,
   // Register port
   input  wire [3:0]        reg_addr,
   input  wire [31:0]       reg_wdata,
   input  wire              reg_wr,
   input  wire              reg_rd,
   output reg  [31:0]       reg_rdata,
   // Request inputs
   input  wire [NCH-1:0]    ext_req,
   input  wire [3:0]        periph_tx_req,
   input  wire [3:0]        periph_rx_req,
   input  wire              nmi_event,
   input  wire              addr_error_event,
   // Unit output stream
   output wire              unit_valid,
   output wire [2:0]        unit_channel,
   output wire [1:0]        unit_size,
   input  wire              unit_ready,
   output reg               bus_hold,
   output reg               transfer_end_irq
);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [15:0]      req_select_ch2_ch3_reg;
   reg [15:0]      req_select_ch4_ch5_reg;
   reg             master_enable_reg;
   reg             nmi_flag_reg;
   reg             addr_error_flag_reg;
   reg [11:0]      chctl_reg [0:NCH-1];
   reg [CNT_W-1:0] transfer_count_reg [0:NCH-1];

   // Two-entry buffer
   reg [4:0]       buf_data_reg [0:1];
   reg             buf_wp_reg;
   reg             buf_rp_reg;
   reg [1:0]       buf_cnt_reg;

   integer         i;
   integer         j;
   integer         k;
   integer         n;

   // ----------------------------------------
   // Selector decode
   // ----------------------------------------
   // Code = {module_id, register_id}; unknown codes yield no request
   function periph_pick;
      input [7:0] code;
      input [3:0] tx;
      input [3:0] rx;
      reg   [3:0] v;
      begin
         v = (code[1:0] == `DRS_RID_TX) ? tx : rx;
         periph_pick = 1'b0;
         if (code[1:0] == `DRS_RID_TX || code[1:0] == `DRS_RID_RX) begin
            case (code[7:2])
               `DRS_MID_UART0: periph_pick = v[0];
               `DRS_MID_UART1: periph_pick = v[1];
               `DRS_MID_SYNC0: periph_pick = v[2];
               `DRS_MID_SYNC1: periph_pick = v[3];
               default:        periph_pick = 1'b0;
            endcase
         end
      end
   endfunction

   // Channel index of a word inside a block of per-channel registers
   function [2:0] chan_of;
      input [3:0] addr;
      input [3:0] base;
      reg   [3:0] diff;
      begin
         diff    = addr - base;
         chan_of = diff[2:0];
      end
   endfunction

   reg [7:0] sel_code [0:NCH-1];
   always @* begin
      // No selector here for channels 0 and 1
      sel_code[0] = 8'h00;
      sel_code[1] = 8'h00;
      sel_code[2] = req_select_ch2_ch3_reg[`DRS_LO_MID_MSB:`DRS_LO_RID_LSB];
      sel_code[3] = req_select_ch2_ch3_reg[`DRS_HI_MID_MSB:`DRS_HI_RID_LSB];
      sel_code[4] = req_select_ch4_ch5_reg[`DRS_LO_MID_MSB:`DRS_LO_RID_LSB];
      sel_code[5] = req_select_ch4_ch5_reg[`DRS_HI_MID_MSB:`DRS_HI_RID_LSB];
   end

   // ----------------------------------------
   // Enable and request per channel
   // ----------------------------------------
   reg [NCH-1:0] ch_ok;
   reg [NCH-1:0] ch_req;
   reg [3:0]     rs;
   always @* begin
      rs     = 4'h0;
      ch_ok  = {NCH{1'b0}};
      ch_req = {NCH{1'b0}};

      for (j = 0; j < NCH; j = j + 1) begin
         ch_ok[j] = chctl_reg[j][`DRS_CC_EN] & master_enable_reg & ~chctl_reg[j][`DRS_CC_END]
                  & ~addr_error_flag_reg & ~nmi_flag_reg;
         rs = chctl_reg[j][`DRS_CC_RS_MSB:`DRS_CC_RS_LSB];
         case (rs)
            `DRS_RS_AUTO: begin
               ch_req[j] = ch_ok[j];
            end
            `DRS_RS_EXT: begin
               ch_req[j] = ext_req[j] & ch_ok[j];
            end
            `DRS_RS_PERIPH: begin
               ch_req[j] = periph_pick(sel_code[j], periph_tx_req, periph_rx_req) & ch_ok[j];
            end
            default: begin
               ch_req[j] = 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Fixed priority, channel 0 highest
   // ----------------------------------------
   reg [2:0] win;
   reg       win_v;
   always @* begin
      win   = 3'h0;
      win_v = 1'b0;
      for (k = NCH - 1; k >= 0; k = k - 1) begin
         if (ch_req[k]) begin
            win   = k[2:0];
            win_v = 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Request acceptance
   // ----------------------------------------
   // Cycle steal leaves an idle cycle after each unit
   wire buf_in_ready = (buf_cnt_reg != 2'h2);
   wire take = ce & win_v & buf_in_ready & (chctl_reg[win][`DRS_CC_BURST] | ~bus_hold);

   // ----------------------------------------
   // Register write and flow
   // ----------------------------------------
   // Control words and counts sit in separate blocks so no word has two owners
   wire       sel_ctl    = (reg_addr >= `DRS_ADDR_CHCTL0) & (reg_addr < `DRS_ADDR_CHCTL0 + NCH);
   wire       sel_cnt    = (reg_addr >= `DRS_ADDR_CNT_BASE) & (reg_addr < `DRS_ADDR_CNT_BASE + NCH);
   wire       wr_ctl     = reg_wr & sel_ctl;
   wire       wr_cnt     = reg_wr & sel_cnt;
   wire [2:0] wr_idx_ctl = chan_of(reg_addr, `DRS_ADDR_CHCTL0);
   wire [2:0] wr_idx_cnt = chan_of(reg_addr, `DRS_ADDR_CNT_BASE);
   wire       cnt_last   = (transfer_count_reg[win] == {{(CNT_W-1){1'b0}}, 1'b1});

   // ----------------------------------------
   // Request selectors
   // ----------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         req_select_ch2_ch3_reg <= `DRS_SEL_RESET;
         req_select_ch4_ch5_reg <= `DRS_SEL_RESET;
      end else if (ce) begin
         if (reg_wr && reg_addr == `DRS_ADDR_SEL23) begin
            req_select_ch2_ch3_reg <= reg_wdata[15:0];
         end
         if (reg_wr && reg_addr == `DRS_ADDR_SEL45) begin
            req_select_ch4_ch5_reg <= reg_wdata[15:0];
         end
      end
   end

   // ----------------------------------------
   // Operation control and abort flags
   // ----------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         master_enable_reg   <= 1'b0;
         nmi_flag_reg        <= 1'b0;
         addr_error_flag_reg <= 1'b0;
      end else if (ce) begin
         if (reg_wr && reg_addr == `DRS_ADDR_OPCTL) begin
            master_enable_reg <= reg_wdata[`DRS_OC_MASTER];
            // Flags clear by writing zero; a same-cycle event wins
            if (!reg_wdata[`DRS_OC_NMI]) begin
               nmi_flag_reg <= 1'b0;
            end
            if (!reg_wdata[`DRS_OC_AERR]) begin
               addr_error_flag_reg <= 1'b0;
            end
         end
         // Sticky, so an abort cannot slip past a busy channel
         if (nmi_event) begin
            nmi_flag_reg <= 1'b1;
         end
         if (addr_error_event) begin
            addr_error_flag_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Channel control
   // ----------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (i = 0; i < NCH; i = i + 1) begin
            chctl_reg[i] <= 12'h000;
         end
      end else if (ce) begin
         // End flag: writing zero clears, one is ignored; hardware set wins
         if (wr_ctl) begin
            chctl_reg[wr_idx_ctl] <= {reg_wdata[11:2], reg_wdata[1] & chctl_reg[wr_idx_ctl][1], reg_wdata[0]};
         end
         if (take && cnt_last) begin
            chctl_reg[win][`DRS_CC_END] <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Transfer counts
   // ----------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         for (n = 0; n < NCH; n = n + 1) begin
            transfer_count_reg[n] <= {CNT_W{1'b0}};
         end
      end else if (ce) begin
         // A count of zero wraps and keeps going; program nonzero
         if (wr_cnt) begin
            transfer_count_reg[wr_idx_cnt] <= reg_wdata[CNT_W-1:0];
         end
         if (take) begin
            transfer_count_reg[win] <= transfer_count_reg[win] - {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ----------------------------------------
   // Bus hold and end pulse
   // ----------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         bus_hold         <= 1'b0;
         transfer_end_irq <= 1'b0;
      end else if (ce) begin
         bus_hold         <= take;
         transfer_end_irq <= take & cnt_last & chctl_reg[win][`DRS_CC_IE];
      end
   end

   // ----------------------------------------
   // Two-entry unit buffer
   // ----------------------------------------
   wire pop = unit_valid & unit_ready & ce;
   assign unit_valid   = (buf_cnt_reg != 2'h0);
   assign unit_channel = buf_data_reg[buf_rp_reg][4:2];
   assign unit_size    = buf_data_reg[buf_rp_reg][1:0];

   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         buf_wp_reg      <= 1'b0;
         buf_rp_reg      <= 1'b0;
         buf_cnt_reg     <= 2'h0;
         buf_data_reg[0] <= 5'h00;
         buf_data_reg[1] <= 5'h00;
      end else if (ce) begin
         if (take) begin
            buf_data_reg[buf_wp_reg] <= {win, chctl_reg[win][`DRS_CC_TS_MSB:`DRS_CC_TS_LSB]};
            buf_wp_reg <= ~buf_wp_reg;
         end
         if (pop) begin
            buf_rp_reg <= ~buf_rp_reg;
         end
         // Push and pop together leave the fill level alone
         if (take & ~pop) begin
            buf_cnt_reg <= buf_cnt_reg + 2'h1;
         end else if (pop & ~take) begin
            buf_cnt_reg <= buf_cnt_reg - 2'h1;
         end
      end
   end

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (ce) begin
         // Data stand one cycle only; idle cycles read zero
         reg_rdata <= 32'h0000_0000;
         if (reg_rd) begin
            case (reg_addr)
               `DRS_ADDR_SEL23: begin
                  reg_rdata <= {16'h0000, req_select_ch2_ch3_reg};
               end
               `DRS_ADDR_SEL45: begin
                  reg_rdata <= {16'h0000, req_select_ch4_ch5_reg};
               end
               `DRS_ADDR_OPCTL: begin
                  reg_rdata <= {29'h0000_0000, addr_error_flag_reg, nmi_flag_reg, master_enable_reg};
               end
               default: begin
                  if (sel_ctl) begin
                     reg_rdata <= {20'h0_0000, chctl_reg[wr_idx_ctl]};
                  end else if (sel_cnt) begin
                     reg_rdata <= {{(32-CNT_W){1'b0}}, transfer_count_reg[wr_idx_cnt]};
                  end
               end
            endcase
         end
      end
   end

endmodule // drs_flow

`default_nettype wire

// *** test/drs_flow_checker.sv ***
`default_nettype none
module drs_flow_checker (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        ce,
   // Register port
   input wire logic [3:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Stream and events
   input wire logic        nmi_event,
   input wire logic        unit_valid,
   input wire logic [2:0]  unit_channel,
   input wire logic [1:0]  unit_size,
   input wire logic        unit_ready,
   input wire logic        bus_hold,
   input wire logic        transfer_end_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   property p_rd_idle; !($past(reg_rd) && $past(ce)) |-> reg_rdata == 32'h0000_0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
   property p_sel_back;
      reg_wr && ce && reg_addr == 4'h0 ##1 !reg_wr ##1 reg_rd && ce && reg_addr == 4'h0
      |=> reg_rdata == {16'h0000, $past(reg_wdata[15:0], 3)};
   endproperty
   a_sel_back: assert property (p_sel_back) else $error("selector readback wrong");
   property p_sel_hi; reg_rd && ce && reg_addr == 4'h1 |=> reg_rdata[31:16] == 16'h0000; endproperty
   a_sel_hi: assert property (p_sel_hi) else $error("selector upper bits set");
   property p_hold;
      unit_valid && !unit_ready |=> unit_valid && $stable(unit_channel) && $stable(unit_size);
   endproperty
   a_hold: assert property (p_hold) else $error("stalled unit lost");
   property p_hold_unit; bus_hold |-> unit_valid; endproperty
   a_hold_unit: assert property (p_hold_unit) else $error("bus held without a unit");
   property p_irq_pulse; transfer_end_irq |=> !transfer_end_irq; endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("end pulse too long");
   property p_irq_unit; transfer_end_irq |-> unit_valid; endproperty
   a_irq_unit: assert property (p_irq_unit) else $error("end without unit");
   property p_master_off;
      reg_wr && ce && reg_addr == 4'h2 && !reg_wdata[0] |=> ##1 !transfer_end_irq [*4];
   endproperty
   a_master_off: assert property (p_master_off) else $error("end after master off");
   property p_nmi_off; nmi_event && ce |=> ##1 !transfer_end_irq [*4]; endproperty
   a_nmi_off: assert property (p_nmi_off) else $error("end after nmi");
endmodule // drs_flow_checker
bind drs_flow drs_flow_checker drs_flow_checker_inst (
   .mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nmi_event(nmi_event), .unit_valid(unit_valid),
   .unit_channel(unit_channel), .unit_size(unit_size), .unit_ready(unit_ready), .bus_hold(bus_hold),
   .transfer_end_irq(transfer_end_irq)
);
`default_nettype wire

// *** test/drs_sink.sv ***
`default_nettype none
module drs_sink (
   // Clock and control
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       stall,
   // Unit stream
   input wire logic       unit_valid,
   input wire logic [2:0] unit_channel,
   input wire logic [1:0] unit_size,
   output logic           unit_ready,
   // Tallies
   output logic [7:0]     n_ch2,
   output logic [7:0]     n_all,
   output logic [1:0]     last_size
);
   timeunit 1ns;
   timeprecision 1ps;
   // Memory may hold off; a stalled unit must wait in the buffer
   assign unit_ready = !stall;
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         n_ch2 <= 8'h00;
         n_all <= 8'h00;
         last_size <= 2'b00;
      end else if (unit_valid && unit_ready) begin
         n_all <= n_all + 8'h01;
         last_size <= unit_size;
         if (unit_channel == 3'h2) n_ch2 <= n_ch2 + 8'h01;
      end
   end
endmodule // drs_sink
`default_nettype wire

// *** test/testbench.sv ***
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [3:0]  reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [31:0] reg_rdata, v;
   logic [5:0]  ext_req = 6'h00;
   logic [3:0]  periph_tx_req = 4'h0;
   logic [3:0]  periph_rx_req = 4'h0;
   logic        nmi_event = 1'b0;
   logic        addr_error_event = 1'b0;
   logic        stall = 1'b0;
   logic        unit_valid, unit_ready, bus_hold, transfer_end_irq;
   logic [2:0]  unit_channel;
   logic [1:0]  unit_size, last_size;
   logic [7:0]  n_ch2, n_all;
   logic [7:0]  n_irq = 8'h00;
   logic [3:0]  lg;
   logic [7:0]  codes [8] = '{8'h21, 8'h22, 8'h29, 8'h2A, 8'h51, 8'h52, 8'h55, 8'h56};
   int          num_errors = 0;
   int          n_checks = 0;
   int          cyc = 0;
   drs_flow drs_flow_inst (
      .mclk(mclk), .rst(rst), .ce(1'b1),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ext_req(ext_req), .periph_tx_req(periph_tx_req), .periph_rx_req(periph_rx_req),
      .nmi_event(nmi_event), .addr_error_event(addr_error_event),
      .unit_valid(unit_valid), .unit_channel(unit_channel), .unit_size(unit_size), .unit_ready(unit_ready),
      .bus_hold(bus_hold), .transfer_end_irq(transfer_end_irq)
   );
   drs_sink drs_sink_inst (
      .mclk(mclk), .rst(rst), .stall(stall),
      .unit_valid(unit_valid), .unit_channel(unit_channel), .unit_size(unit_size), .unit_ready(unit_ready),
      .n_ch2(n_ch2), .n_all(n_all), .last_size(last_size)
   );
   always #2.5 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (transfer_end_irq === 1'b1) n_irq <= n_irq + 8'h01;
      if (cyc == 6000) begin
         num_errors = num_errors + 1;
         report_and_stop;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      d = reg_rdata;
   endtask
   // ----------------------------------------
   // One channel-2 session, stall first
   // ----------------------------------------
   task automatic run(input logic [31:0] cc, input logic [7:0] sel, input logic [31:0] cnt,
                      input logic [3:0] tx, input logic [3:0] rx, input logic [5:0] ex,
                      input logic [1:0] ev, input logic [31:0] om, input int st,
                      input logic [7:0] eu, input logic [7:0] ei);
      logic [7:0] b2, ba, bi;
      b2 = n_ch2;
      ba = n_all;
      bi = n_irq;
      nmi_event <= ev[0];
      addr_error_event <= ev[1];
      stall <= (st > 0);
      wr(4'h0, {24'h00_0000, sel});
      wr(4'hB, cnt);
      wr(4'h2, om);
      wr(4'h5, cc);
      periph_tx_req <= tx;
      periph_rx_req <= rx;
      ext_req <= ex;
      repeat (st) @(posedge mclk);
      stall <= 1'b0;
      repeat (40) @(posedge mclk);
      {periph_tx_req, periph_rx_req, ext_req, nmi_event, addr_error_event} <= 16'h0000;
      wr(4'h5, 32'h0000_0000);
      chk(n_ch2 - b2, eu);
      chk(n_all - ba, eu);
      chk(n_irq - bi, ei);
      if (eu != 8'h00) chk(last_size, cc[5:4]);
   endtask
   task automatic report_and_stop;
      if (num_errors == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      rd(4'h0, v); chk(v, 32'h0000_0000);
      rd(4'h1, v); chk(v, 32'h0000_0000);
      wr(4'h0, 32'hFFFF_2921);
      rd(4'h0, v); chk(v, 32'h0000_2921);
      wr(4'h1, 32'h0000_5655);
      rd(4'h1, v); chk(v, 32'h0000_5655);
      rd(4'hF, v); chk(v, 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
         lg = 4'h1 << (i / 2);
         run(32'h0000_0805, codes[i], 2, i % 2 ? 4'h0 : lg, i % 2 ? lg : 4'h0, 6'h00, 2'b00, 1, 0, 2, 1);
      end
      run(32'h0000_0805, 8'h23, 2, 4'hF, 4'hF, 6'h00, 2'b00, 1, 0, 0, 0);
      run(32'h0000_0805, 8'h21, 2, 4'hE, 4'hF, 6'h00, 2'b00, 1, 0, 0, 0);
      run(32'h0000_0005, 8'h21, 2, 4'h1, 4'h0, 6'h00, 2'b00, 1, 0, 0, 0);
      run(32'h0000_0005, 8'h21, 2, 4'h0, 4'h0, 6'h04, 2'b00, 1, 0, 2, 1);
      run(32'h0000_0405, 8'h00, 3, 4'h0, 4'h0, 6'h00, 2'b00, 1, 0, 3, 1);
      run(32'h0000_0401, 8'h00, 3, 4'h0, 4'h0, 6'h00, 2'b00, 1, 0, 3, 0);
      run(32'h0000_042D, 8'h00, 4, 4'h0, 4'h0, 6'h00, 2'b00, 1, 0, 4, 1);
      run(32'h0000_0405, 8'h00, 6, 4'h0, 4'h0, 6'h00, 2'b00, 1, 20, 6, 1);
      run(32'h0000_0405, 8'h00, 3, 4'h0, 4'h0, 6'h00, 2'b00, 0, 0, 0, 0);
      run(32'h0000_0405, 8'h00, 3, 4'h0, 4'h0, 6'h00, 2'b01, 1, 0, 0, 0);
      run(32'h0000_0405, 8'h00, 3, 4'h0, 4'h0, 6'h00, 2'b10, 1, 0, 0, 0);
      run(32'h0000_0405, 8'h00, 1, 4'h0, 4'h0, 6'h00, 2'b00, 1, 0, 1, 1);
      report_and_stop;
   end
endmodule // testbench
`default_nettype wire
